/* File: pkg/pccr_pkg.sv */
package pccr_pkg;
    // register byte offsets
    localparam logic [7:0] PCCR_OFS_EEPROM = 8'hbc;
    localparam logic [7:0] PCCR_OFS_EXPCAP = 8'hc0;
    localparam logic [7:0] PCCR_OFS_DEVCAP = 8'hc4;
    // eeprom dword fields
    localparam int PCCR_EE_START_BIT = 0;
    localparam int PCCR_EE_CMD_BIT = 1;
    localparam int PCCR_EE_ERR_BIT = 2;
    localparam int PCCR_EE_ADDR_LSB = 9;
    localparam int PCCR_EE_ADDR_W = 7;
    localparam int PCCR_EE_DATA_LSB = 16;
    localparam int PCCR_EE_DATA_W = 16;
    localparam logic [6:0] PCCR_EE_ADDR_RST = 7'h00;
    localparam logic [15:0] PCCR_EE_DATA_RST = 16'h0000;
    // express capability header fields
    localparam logic [7:0] PCCR_CAP_ID = 8'h10;
    localparam logic [7:0] PCCR_NEXT_PTR = 8'h00;
    localparam logic [3:0] PCCR_CAP_VER = 4'h2;
    localparam logic [3:0] PCCR_TYPE_UP = 4'h5;
    localparam logic [3:0] PCCR_TYPE_DOWN = 4'h6;
    localparam logic [4:0] PCCR_MSG_NUM = 5'h00;
    localparam int PCCR_TYPE_LSB = 20;
    localparam int PCCR_SLOT_BIT = 24;
    localparam int PCCR_MSG_LSB = 25;
    // device capabilities fields
    localparam logic [2:0] PCCR_MPS_SMALL = 3'h1;
    localparam logic [2:0] PCCR_MPS_LARGE = 3'h2;
    localparam logic [1:0] PCCR_PHANTOM = 2'h0;
    localparam logic PCCR_EXT_TAG = 1'b0;
    localparam logic [2:0] PCCR_L0S_LAT = 3'h0;
    localparam logic [2:0] PCCR_L1_LAT = 3'h0;
    localparam logic PCCR_RBER_RST = 1'b1;
    localparam logic [7:0] PCCR_SPL_VAL_RST = 8'h00;
    localparam logic [1:0] PCCR_SPL_SCL_RST = 2'h0;
    localparam int PCCR_PHANTOM_LSB = 3;
    localparam int PCCR_EXT_TAG_BIT = 5;
    localparam int PCCR_L0S_LSB = 6;
    localparam int PCCR_L1_LSB = 9;
    localparam int PCCR_RBER_BIT = 15;
    localparam int PCCR_SPL_VAL_LSB = 18;
    localparam int PCCR_SPL_SCL_LSB = 26;

    // loading path from smbus or eeprom autoload
    typedef struct packed {
        logic slot_present;
        logic [2:0] max_payload;
        logic role_err;
    } pccr_load_t;

    // received slot power limit message payload
    typedef struct packed {
        logic [7:0] value;
        logic [1:0] scale;
    } pccr_spl_t;

    // request to the eeprom access engine
    typedef struct packed {
        logic start;
        logic write;
        logic [6:0] addr;
        logic [15:0] wdata;
    } pccr_ee_req_t;

    // answer from the eeprom access engine
    typedef struct packed {
        logic done;
        logic nack;
        logic [15:0] rdata;
    } pccr_ee_rsp_t;
endpackage : pccr_pkg

/* File: rtl/pccr_regs.sv */
`timescale 1ns/100ps
module pccr_regs #(
    parameter bit UPSTREAM = 1'b1
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // avalon-mm slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // straps
    input wire logic slot_present_strap_in,
    input wire logic large_payload_strap_in,
    // smbus / eeprom loading
    input wire logic cfg_load_valid_in,
    input wire pccr_pkg::pccr_load_t cfg_load_in,
    // slot power limit message receiver
    input wire logic spl_msg_valid_in,
    input wire pccr_pkg::pccr_spl_t spl_msg_in,
    // eeprom access engine
    output pccr_pkg::pccr_ee_req_t ee_req_out,
    input wire pccr_pkg::pccr_ee_rsp_t ee_rsp_in,
    output logic ee_busy_out
);
    import pccr_pkg::*;

    logic wait_reg;
    logic [31:0] rdata_reg;
    logic strap_done_reg;
    logic slot_reg;
    logic [2:0] mps_reg;
    logic rber_reg;
    logic [7:0] spl_val_reg;
    logic [1:0] spl_scl_reg;
    logic ee_busy_reg;
    logic ee_start_reg;
    logic ee_cmd_reg;
    logic ee_err_reg;
    logic [6:0] ee_addr_reg;
    logic [15:0] ee_data_reg;
    logic acc;
    logic wr_ok;
    logic rd_ok;
    logic sel_ee;
    logic sel_cap;
    logic sel_dev;
    logic start_req;
    logic [3:0] port_type;
    logic [31:0] ee_word;
    logic [31:0] cap_word;
    logic [31:0] dev_word;
    logic [31:0] rdata_next;

    // a request is served once; the edge with waitrequest low commits it
    // first edge with a request seen: waitrequest drops, read word latched
    // second edge: master samples waitrequest low, a write takes effect
    // reads latch early so the word stands for the whole low cycle
    // writes wait for the low cycle so a dropped request never commits
    // trade-off: every access costs two cycles, no back-to-back streaming
    assign acc = (avs_read_in | avs_write_in) & wait_reg;
    assign wr_ok = avs_write_in & ~wait_reg;
    assign rd_ok = avs_read_in & wait_reg;

    // address decode, word aligned
    // byte address bits 1:0 ignored, lanes picked by byteenable instead
    // only the three dwords of this block decode, the rest reads zero
    // decode is purely combinational on the held address
    assign sel_ee = (avs_address_in[7:2] == PCCR_OFS_EEPROM[7:2]);
    assign sel_cap = (avs_address_in[7:2] == PCCR_OFS_EXPCAP[7:2]);
    assign sel_dev = (avs_address_in[7:2] == PCCR_OFS_DEVCAP[7:2]);

    // start only honoured while idle, so an access in flight is never restarted
    // lane 0 carries start and command, so byteenable[0] gates both
    // a start written while busy is dropped, not queued
    // software polls bit 0 to learn when the engine is free again
    assign start_req = wr_ok & sel_ee & avs_byteenable_in[0]
                     & avs_writedata_in[PCCR_EE_START_BIT] & ~ee_busy_reg;

    // port type fixed by which port this instance serves
    // elaboration-time choice, no strap or load path can move it
    // one instance per port, upstream set on exactly one of them
    assign port_type = UPSTREAM ? PCCR_TYPE_UP : PCCR_TYPE_DOWN;

    // one cycle answer: waitrequest drops for exactly one cycle
    // high at rest so a master never sees a stale acknowledge
    // returns high right after the commit edge, even if the request stays
    // a request still standing then is taken as a fresh access
    // no error response exists, refused accesses still complete
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_reg <= 1'b1;
        end else if (acc) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    // read word assembly
    // all three dwords are built every cycle and muxed by the decode
    // constant fields come from the package, live ones from the registers
    // reserved bits stay zero through the defaults at the top
    // cheap in area: the constants fold away, only a few flops remain
    always_comb begin
        ee_word = 32'h0000_0000;
        ee_word[PCCR_EE_START_BIT] = ee_busy_reg;
        ee_word[PCCR_EE_CMD_BIT] = ee_cmd_reg;
        ee_word[PCCR_EE_ERR_BIT] = ee_err_reg;
        ee_word[PCCR_EE_ADDR_LSB +: PCCR_EE_ADDR_W] = ee_addr_reg;
        ee_word[PCCR_EE_DATA_LSB +: PCCR_EE_DATA_W] = ee_data_reg;
        cap_word = 32'h0000_0000;
        cap_word[7:0] = PCCR_CAP_ID;
        cap_word[15:8] = PCCR_NEXT_PTR;
        cap_word[19:16] = PCCR_CAP_VER;
        cap_word[PCCR_TYPE_LSB +: 4] = port_type;
        cap_word[PCCR_SLOT_BIT] = slot_reg;
        cap_word[PCCR_MSG_LSB +: 5] = PCCR_MSG_NUM;
        dev_word = 32'h0000_0000;
        dev_word[2:0] = mps_reg;
        dev_word[PCCR_PHANTOM_LSB +: 2] = PCCR_PHANTOM;
        dev_word[PCCR_EXT_TAG_BIT] = PCCR_EXT_TAG;
        dev_word[PCCR_L0S_LSB +: 3] = PCCR_L0S_LAT;
        dev_word[PCCR_L1_LSB +: 3] = PCCR_L1_LAT;
        dev_word[PCCR_RBER_BIT] = rber_reg;
        dev_word[PCCR_SPL_VAL_LSB +: 8] = spl_val_reg;
        dev_word[PCCR_SPL_SCL_LSB +: 2] = spl_scl_reg;
        // unmapped offsets read as zero
        // the eeprom dword exists on the upstream port only
        // downstream ports read it as zero, like any hole in the map
        if (sel_ee && UPSTREAM) begin
            rdata_next = ee_word;
        end else if (sel_cap) begin
            rdata_next = cap_word;
        end else if (sel_dev) begin
            rdata_next = dev_word;
        end else begin
            rdata_next = 32'h0000_0000;
        end
    end

    // read data registered alongside the waitrequest drop
    // holds until the next read answer, writes leave it untouched
    // keeps the readdata output straight from a flip-flop
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_ok) begin
            rdata_reg <= rdata_next;
        end
    end

    // bus outputs come straight from their flops
    assign avs_readdata_out = rdata_reg;
    assign avs_waitrequest_out = wait_reg;

    // straps sampled on the first edge after reset release, not under reset
    // the async reset branch may only load constants
    // so the strap value lands one edge later, through a marker flop
    // hazard: a load pulse on that same edge loses to the straps
    // limitation: straps must be settled when reset is released
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strap_done_reg <= 1'b0;
        end else begin
            strap_done_reg <= 1'b1;
        end
    end

    // slot present: strap first, then only the loading path
    // configuration writes have no path into this flop
    // stored on every port, only meaningful on downstream ones
    // reads 0 while reset is held, the strap value one edge after
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            slot_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            slot_reg <= slot_present_strap_in;
        end else if (cfg_load_valid_in) begin
            slot_reg <= cfg_load_in.slot_present;
        end
    end

    // max payload supported, strap chooses the default
    // strap low picks the small size, high the large one
    // a load may write any code, no range check is made here
    // the loading side owns the choice of legal sizes
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mps_reg <= PCCR_MPS_SMALL;
        end else if (!strap_done_reg) begin
            mps_reg <= large_payload_strap_in ? PCCR_MPS_LARGE : PCCR_MPS_SMALL;
        end else if (cfg_load_valid_in) begin
            mps_reg <= cfg_load_in.max_payload;
        end
    end

    // role-based error reporting, config writes have no path here
    // no strap for this bit, so it leaves reset already at one
    // only a load pulse can clear or set it afterwards
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rber_reg <= PCCR_RBER_RST;
        end else if (cfg_load_valid_in) begin
            rber_reg <= cfg_load_in.role_err;
        end
    end

    // captured slot power limit, downstream ports stay hardwired to zero
    // value and scale always move together from one message
    // a message on a downstream port is simply ignored
    // last message wins, there is no history kept
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            spl_val_reg <= PCCR_SPL_VAL_RST;
            spl_scl_reg <= PCCR_SPL_SCL_RST;
        end else if (UPSTREAM && spl_msg_valid_in) begin
            spl_val_reg <= spl_msg_in.value;
            spl_scl_reg <= spl_msg_in.scale;
        end
    end

    // eeprom command bit
    // zero selects a read, one a write
    // frozen while busy so the engine sees a steady command
    // written through lane 0 together with the start bit
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ee_cmd_reg <= 1'b0;
        end else if (UPSTREAM && wr_ok && sel_ee && avs_byteenable_in[0] && !ee_busy_reg) begin
            ee_cmd_reg <= avs_writedata_in[PCCR_EE_CMD_BIT];
        end
    end

    // eeprom address, bit 8 is reserved and never stored
    // seven bits through lane 1, frozen while an access runs
    // the engine reads it as a level for the whole access
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ee_addr_reg <= PCCR_EE_ADDR_RST;
        end else if (UPSTREAM && wr_ok && sel_ee && avs_byteenable_in[1] && !ee_busy_reg) begin
            ee_addr_reg <= avs_writedata_in[PCCR_EE_ADDR_LSB +: PCCR_EE_ADDR_W];
        end
    end

    // eeprom data: read completion wins over a software write
    // writes are refused while busy and completion needs busy, so the tie never arises
    // a write command leaves the field alone at completion
    // lanes 2 and 3 each fill one byte of the data word
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ee_data_reg <= PCCR_EE_DATA_RST;
        end else if (ee_busy_reg && ee_rsp_in.done && !ee_cmd_reg) begin
            ee_data_reg <= ee_rsp_in.rdata;
        end else if (UPSTREAM && wr_ok && sel_ee && !ee_busy_reg) begin
            if (avs_byteenable_in[2]) begin
                ee_data_reg[7:0] <= avs_writedata_in[23:16];
            end
            if (avs_byteenable_in[3]) begin
                ee_data_reg[15:8] <= avs_writedata_in[31:24];
            end
        end
    end

    // busy follows start until the engine reports done
    // reads back as bit 0 so software sees start stay set
    // a done pulse while idle changes nothing
    // limitation: a hung engine keeps busy high, no timeout here
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ee_busy_reg <= 1'b0;
        end else if (UPSTREAM && start_req) begin
            ee_busy_reg <= 1'b1;
        end else if (ee_rsp_in.done) begin
            ee_busy_reg <= 1'b0;
        end
    end

    // one-cycle launch pulse to the engine
    // rises on the same edge as busy, lasts exactly one cycle
    // the engine must take it then, it is not repeated
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ee_start_reg <= 1'b0;
        end else begin
            ee_start_reg <= UPSTREAM & start_req;
        end
    end

    // error: cleared by a new start, a missing ack at done sets it
    // set wins if both would fall in one cycle
    // a start cannot meet done anyway, start needs the engine idle
    // the bit keeps its value until the next access starts
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ee_err_reg <= 1'b0;
        end else if (ee_busy_reg && ee_rsp_in.done && ee_rsp_in.nack) begin
            ee_err_reg <= 1'b1;
        end else if (UPSTREAM && start_req) begin
            ee_err_reg <= 1'b0;
        end
    end

    // engine request straight from flip-flops
    // command, address and data are levels held through busy
    // start is the only pulse in the group
    assign ee_req_out.start = ee_start_reg;
    assign ee_req_out.write = ee_cmd_reg;
    assign ee_req_out.addr = ee_addr_reg;
    assign ee_req_out.wdata = ee_data_reg;
    assign ee_busy_out = ee_busy_reg;
endmodule : pccr_regs

/* File: verification/pccr_regs_checker.sv */
`timescale 1ns/100ps
module pccr_regs_checker #(
    parameter bit UPSTREAM = 1'b1
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire pccr_pkg::pccr_ee_req_t ee_req_out,
    input wire pccr_pkg::pccr_ee_rsp_t ee_rsp_in,
    input wire logic ee_busy_out
);
    import pccr_pkg::*;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // bus answers a fresh request exactly one cycle later, for one cycle
    a_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("waitrequest did not drop");
    a_wait_one: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    a_wait_idle: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out
        |=> avs_waitrequest_out) else $error("waitrequest low without request");
    // engine start rises with busy, lasts one cycle
    a_start_pulse: assert property (ee_req_out.start |=> !ee_req_out.start)
        else $error("start longer than one cycle");
    a_busy_start: assert property ($rose(ee_busy_out) |-> ee_req_out.start)
        else $error("busy without start");
    a_busy_done: assert property (ee_busy_out && ee_rsp_in.done |=> !ee_busy_out)
        else $error("busy stuck after done");
    a_req_stable: assert property (ee_busy_out && $past(ee_busy_out)
        |-> $stable(ee_req_out.addr) && $stable(ee_req_out.write))
        else $error("request changed while busy");
    // constant fields of the capability registers
    a_cap_const: assert property (avs_read_in && !avs_waitrequest_out
        && avs_address_in[7:2] == PCCR_OFS_EXPCAP[7:2]
        |-> avs_readdata_out[19:0] == 20'h20010 && avs_readdata_out[31:25] == 7'h00
        && avs_readdata_out[23:20] == (UPSTREAM ? PCCR_TYPE_UP : PCCR_TYPE_DOWN))
        else $error("capability header constant wrong");
    a_devcap_const: assert property (avs_read_in && !avs_waitrequest_out
        && avs_address_in[7:2] == PCCR_OFS_DEVCAP[7:2] |-> avs_readdata_out[11:3] == 9'h000)
        else $error("device capability constant wrong");
endmodule : pccr_regs_checker
bind pccr_regs pccr_regs_checker #(.UPSTREAM(UPSTREAM)) chk_u (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .ee_req_out(ee_req_out),
    .ee_rsp_in(ee_rsp_in), .ee_busy_out(ee_busy_out));

/* File: verification/pccr_regs_tb.sv */
`timescale 1ns/100ps
module pccr_regs_tb;
    import pccr_pkg::*;
    logic clk_sys_in, rst_n_in, rd, wr, slot_s, large_s, ld_v, spl_v, busy, waitreq;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata, got;
    logic waitreq_dn, busy_dn;
    logic [31:0] rdata_dn, got_dn;
    pccr_ee_req_t req_dn;
    pccr_load_t ld;
    pccr_spl_t spl;
    pccr_ee_req_t req;
    pccr_ee_rsp_t rsp;
    int bad_count, samples_checked;
    pccr_regs #(.UPSTREAM(1'b1)) dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be),
        .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .slot_present_strap_in(slot_s), .large_payload_strap_in(large_s),
        .cfg_load_valid_in(ld_v), .cfg_load_in(ld), .spl_msg_valid_in(spl_v),
        .spl_msg_in(spl), .ee_req_out(req), .ee_rsp_in(rsp), .ee_busy_out(busy));
    // downstream port on the same bus, answers in step with dut_u
    pccr_regs #(.UPSTREAM(1'b0)) dut_dn_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be),
        .avs_writedata_in(wdata), .avs_readdata_out(rdata_dn),
        .avs_waitrequest_out(waitreq_dn),
        .slot_present_strap_in(slot_s), .large_payload_strap_in(large_s),
        .cfg_load_valid_in(ld_v), .cfg_load_in(ld), .spl_msg_valid_in(spl_v),
        .spl_msg_in(spl), .ee_req_out(req_dn), .ee_rsp_in(rsp), .ee_busy_out(busy_dn));
    // 250 MHz
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : check
    // one bus cycle; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr <= a; wdata <= d; be <= 4'hf; rd <= !w; wr <= w;
        do begin
            @(posedge clk_sys_in);
        end while (waitreq !== 1'b0);
        got = rdata;
        got_dn = rdata_dn;
        check({31'h0, waitreq_dn}, 32'h0);
        rd <= 1'b0; wr <= 1'b0;
    endtask : bus
    task automatic ee_finish(input logic nack, input logic [15:0] d);
        @(posedge clk_sys_in);
        check({31'h0, busy}, 32'h1);
        rsp <= '{done: 1'b1, nack: nack, rdata: d};
        @(posedge clk_sys_in);
        rsp.done <= 1'b0;
    endtask : ee_finish
    task automatic t_reset_ro;
        bus(0, PCCR_OFS_EEPROM, 0); check(got, 32'h0);
        check(got_dn, 32'h0);
        bus(1, PCCR_OFS_EXPCAP, 32'hffffffff); bus(1, PCCR_OFS_DEVCAP, 32'hffffffff);
        bus(0, PCCR_OFS_EXPCAP, 0); check(got, 32'h01520010);
        check(got_dn, 32'h01620010);
        bus(0, PCCR_OFS_DEVCAP, 0); check(got, 32'h00008002);
        check(got_dn, 32'h00008002);
        bus(1, 8'h00, 32'hffffffff); bus(0, 8'h00, 0); check(got, 32'h0);
    endtask : t_reset_ro
    task automatic t_load_spl;
        @(posedge clk_sys_in);
        ld <= '{slot_present: 1'b0, max_payload: 3'h1, role_err: 1'b0}; ld_v <= 1'b1;
        spl <= '{value: 8'ha5, scale: 2'h3}; spl_v <= 1'b1;
        @(posedge clk_sys_in);
        ld_v <= 1'b0; spl_v <= 1'b0;
        bus(0, PCCR_OFS_EXPCAP, 0); check(got, 32'h00520010);
        bus(0, PCCR_OFS_DEVCAP, 0); check(got, 32'h0e940001);
        check(got_dn, 32'h00000001);
    endtask : t_load_spl
    task automatic t_ee_read;
        bus(1, PCCR_OFS_EEPROM, 32'h1234ab01);
        bus(0, PCCR_OFS_EEPROM, 0); check(got, 32'h1234aa01);
        check({req.write, req.addr}, 8'h55);
        check({31'h0, busy_dn}, 32'h0);
        ee_finish(1'b1, 16'hbeef);
        bus(0, PCCR_OFS_EEPROM, 0); check(got, 32'hbeefaa04);
    endtask : t_ee_read
    task automatic t_ee_write;
        bus(1, PCCR_OFS_EEPROM, 32'hc33cff03);
        @(negedge clk_sys_in);
        check({req.write, req.addr, req.wdata}, 24'hffc33c);
        ee_finish(1'b0, 16'hdead);
        bus(0, PCCR_OFS_EEPROM, 0); check(got, 32'hc33cfe02);
    endtask : t_ee_write
    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    // stops a hung run; tests need about 55 cycles
    initial begin
        #20000;
        bad_count++;
        end_sim();
    end
    initial begin
        rst_n_in = 1'b0; rd = 1'b0; wr = 1'b0; addr = 8'h00; be = 4'h0; wdata = 32'h0;
        slot_s = 1'b1; large_s = 1'b1; ld_v = 1'b0; spl_v = 1'b0; ld = '0; spl = '0;
        rsp = '0; bad_count = 0; samples_checked = 0;
        repeat (3) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        t_reset_ro();
        t_load_spl();
        t_ee_read();
        t_ee_write();
        end_sim();
    end
endmodule : pccr_regs_tb
